// >>> siv_pkg.sv
// Purpose: shared constants for the subsystem interrupt vectoring block
// Assumes: one processor subsystem per instance, 16-bit pending and mask flags
// Notes:   rank tables are indexed by hardware rank, rank 0 serviced first
`default_nettype none
package siv_pkg;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int FLAG_W   = 16;
  localparam int NUM_RANK = 14;
  localparam int RANK_W   = 4;
  localparam int PRIO_W   = 5;
  localparam int VEC_W    = 16;
  localparam int OFF_W    = 7;
  localparam int ROUTE_W  = 4;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_PENDING = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MASK    = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ROUTE   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_VBASE   = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_HOSTCTL = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h14;
  localparam logic [ADDR_W-1:0] REG_SOFTRST = 8'h18;

  // pending and mask flag positions
  localparam int BIT_EXT    = 0;
  localparam int BIT_WDOG   = 1;
  localparam int BIT_TIMER  = 3;
  localparam int BIT_P0RX   = 4;
  localparam int BIT_P0TX   = 5;
  localparam int BIT_SLOT58 = 6;
  localparam int BIT_SLOT5C = 7;
  localparam int BIT_HOST   = 9;
  localparam int BIT_SLOT68 = 10;
  localparam int BIT_SLOT6C = 11;
  localparam int BIT_DMA4   = 12;
  localparam int BIT_DMA5   = 13;
  localparam logic [FLAG_W-1:0] FLAG_IMPL = 16'h3EFB;

  // route select bits: 0 selects serial port event, 1 selects dma channel
  localparam int ROUTE_SLOT58 = 0;
  localparam int ROUTE_SLOT5C = 1;
  localparam int ROUTE_SLOT68 = 2;
  localparam int ROUTE_SLOT6C = 3;

  // control and status fields
  localparam int HOSTCTL_REQ_BIT  = 0;
  localparam int SOFTRST_BIT      = 0;
  localparam int STATUS_VALID_BIT = 31;
  localparam int STATUS_RANK_LSB  = 24;
  localparam int STATUS_PRIO_LSB  = 16;

  // reset values
  localparam logic [FLAG_W-1:0]  MASK_RST  = 16'h0000;
  localparam logic [ROUTE_W-1:0] ROUTE_RST = 4'h0;
  localparam logic [VEC_W-1:0]   VBASE_RST = 16'h0000;
  localparam logic [VEC_W-1:0]   VBASE_KEEP = 16'hFF80;

  // per-rank tables, rank 0 at the right
  localparam int RANK_RESET = 0;
  localparam int RANK_NMI   = 1;
  localparam int RANK_FIRST = 2;
  localparam logic [NUM_RANK-1:0][OFF_W-1:0] RANK_OFFSET = {
    7'h74, 7'h70, 7'h6C, 7'h68, 7'h64, 7'h5C, 7'h58,
    7'h54, 7'h50, 7'h4C, 7'h44, 7'h40, 7'h04, 7'h00};
  localparam logic [NUM_RANK-1:0][PRIO_W-1:0] RANK_PRIO = {
    5'h10, 5'h0F, 5'h0E, 5'h0D, 5'h0C, 5'h0A, 5'h09,
    5'h08, 5'h07, 5'h06, 5'h04, 5'h03, 5'h02, 5'h01};
  localparam logic [NUM_RANK-1:0][3:0] RANK_BIT = {
    4'hD, 4'hC, 4'hB, 4'hA, 4'h9, 4'h7, 4'h6,
    4'h5, 4'h4, 4'h3, 4'h1, 4'h0, 4'h0, 4'h0};

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_RDWAIT = 2'b10
  } siv_bus_state_type;
endpackage
`default_nettype wire

// >>> siv_prio_enc.sv
// Purpose: fixed priority picker, lowest index wins
// Assumes: requests are levels on the same clock
// Notes:   purely combinational
`default_nettype none
`timescale 1ns/1ps
module siv_prio_enc #(
  parameter int N     = 14,
  parameter int IDX_W = 4
) (
  input  wire logic [N-1:0]     req,    // request per rank
  output logic                  valid,  // any request
  output logic [IDX_W-1:0]      idx     // winning rank
);
  logic [N-1:0] blocked;
  logic [N-1:0] grant;

  // one-hot grant, each entry blocked by any lower index
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_rank
      if (i == 0) begin : g_first
        assign blocked[i] = 1'b0;
      end else begin : g_rest
        assign blocked[i] = blocked[i-1] | req[i-1];
      end
      assign grant[i] = req[i] & ~blocked[i];
    end
  endgenerate

  // encode grant to an index
  always_comb begin
    idx   = '0;
    valid = |req;
    for (int k = 0; k < N; k++) begin
      if (grant[k]) begin
        idx = idx | IDX_W'(k);
      end
    end
  end
endmodule
`default_nettype wire

// >>> siv_vectoring.sv
// Purpose: interrupt vectoring and fixed priority for one processor subsystem
// Assumes: on-chip sources share hclk; nmi and ext user pin are asynchronous
// Notes:   registers over ahb-lite; reads take one wait state, writes none
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`default_nettype none
`timescale 1ns/1ps
// Operation
// RULE_01 - hardware or soft reset vectors to 00, highest priority 1
// RULE_02 - nmi at 04 prio 2, ext pin 40 prio 3, watchdog 44 prio 4
// RULE_03 - own map per subsystem; timer 4C/6, dma4 70/15, dma5 74/16
// RULE_04 - serial port 0 receive vectors to 50, priority 7
// RULE_05 - serial port 0 transmit vectors to 54, priority 8
// RULE_06 - 58 prio 9 shared by port 2 receive or dma 0, one at a time
// RULE_07 - 5C prio 10 shared by port 2 transmit or dma 1
// RULE_08 - host request bit raises host interrupt at 64, priority 12
// RULE_09 - 68 prio 13 shared by port 1 receive or dma 2
// RULE_10 - 6C prio 14 shared by port 1 transmit or dma 3
// RULE_11 - pending bit set means pending, mask bit set means enabled; timer bit 3
// RULE_12 - dma 5 uses bit 13 of pending and mask
// RULE_13 - lowest priority number wins; 08 to 3C never hardware vectors
// RULE_14 - 78 to 7F reserved, never produced
module siv_vectoring (
  input  wire logic                        hclk,            // bus clock, 100 MHz
  input  wire logic                        hresetn,         // async reset, active low
  input  wire logic                        hsel,            // slave select
  input  wire logic [siv_pkg::ADDR_W-1:0]  haddr,           // byte address
  input  wire logic [1:0]                  htrans,          // transfer type
  input  wire logic                        hwrite,          // write when high
  input  wire logic [2:0]                  hsize,           // word only
  input  wire logic [siv_pkg::DATA_W-1:0]  hwdata,          // write data
  input  wire logic                        hready,          // bus ready in
  output logic                             hreadyout,       // slave ready
  output logic                             hresp,           // always okay
  output logic [siv_pkg::DATA_W-1:0]       hrdata,          // read data
  input  wire logic                        nmi_irq,         // pin, rising edge
  input  wire logic                        ext_user_irq,    // pin, rising edge
  input  wire logic                        soft_reset_trap, // core pulse
  input  wire logic                        watchdog_irq,    // level source
  input  wire logic                        timer_irq,       // level source
  input  wire logic                        port0_rx_irq,    // level source
  input  wire logic                        port0_tx_irq,    // level source
  input  wire logic                        port1_rx_irq,    // level source
  input  wire logic                        port1_tx_irq,    // level source
  input  wire logic                        port2_rx_irq,    // level source
  input  wire logic                        port2_tx_irq,    // level source
  input  wire logic                        dma_ch0_irq,     // level source
  input  wire logic                        dma_ch1_irq,     // level source
  input  wire logic                        dma_ch2_irq,     // level source
  input  wire logic                        dma_ch3_irq,     // level source
  input  wire logic                        dma_ch4_irq,     // level source
  input  wire logic                        dma_ch5_irq,     // level source
  input  wire logic                        irq_ack,         // core takes vector
  output logic                             irq_req,         // vector offered
  output logic [siv_pkg::VEC_W-1:0]        irq_vector,      // base plus offset
  output logic [siv_pkg::PRIO_W-1:0]       irq_priority     // priority number
);
  import siv_pkg::*;

  siv_bus_state_type   bus_state;
  logic [ADDR_W-1:0]   rd_addr;
  logic [ADDR_W-1:0]   wr_addr;
  logic                wr_pend;
  logic [FLAG_W-1:0]   irq_pending_reg;
  logic [FLAG_W-1:0]   irq_mask_reg;
  logic [ROUTE_W-1:0]  route;
  logic [VEC_W-1:0]    vbase;
  logic                reset_flag;
  logic                nmi_flag;
  logic [1:0]          pin_s1;
  logic [1:0]          pin_s2;
  logic [1:0]          pin_s3;
  logic [FLAG_W-1:0]   src_lvl;
  logic [FLAG_W-1:0]   src_prev;
  logic [FLAG_W-1:0]   set_vec;
  logic [FLAG_W-1:0]   clr_vec;
  logic [FLAG_W-1:0]   ack_clr;
  logic [NUM_RANK-1:0] req;
  logic                pick_valid;
  logic [RANK_W-1:0]   pick_rank;
  logic [RANK_W-1:0]   cur_rank;
  logic                acc;
  logic                ack_take;
  logic                wr_pending_en;
  logic                wr_mask_en;
  logic                wr_route_en;
  logic                wr_vbase_en;
  logic                host_set;
  logic                soft_set;
  logic [DATA_W-1:0]   rd_word;

  assign hresp = 1'b0;
  // reads stall one cycle so a write just ahead is already visible
  assign hreadyout = (bus_state != BUS_RDWAIT);
  assign acc = hsel & hready & htrans[1];

  // bus state and address capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= BUS_IDLE;
      rd_addr   <= '0;
      wr_addr   <= '0;
      wr_pend   <= 1'b0;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          wr_pend <= acc & hwrite;
          if (acc) begin
            if (hwrite) begin
              wr_addr <= haddr;
            end else begin
              rd_addr   <= haddr;
              bus_state <= BUS_RDWAIT;
            end
          end
        end
        BUS_RDWAIT: begin
          wr_pend   <= 1'b0;
          bus_state <= BUS_IDLE;
        end
        default: begin
          wr_pend   <= 1'b0;
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

  // write decode in the data phase; unmapped writes fall through
  assign wr_pending_en = wr_pend & (wr_addr == REG_PENDING);
  assign wr_mask_en    = wr_pend & (wr_addr == REG_MASK);
  assign wr_route_en   = wr_pend & (wr_addr == REG_ROUTE);
  assign wr_vbase_en   = wr_pend & (wr_addr == REG_VBASE);
  assign host_set      = wr_pend & (wr_addr == REG_HOSTCTL) & hwdata[HOSTCTL_REQ_BIT]; // RULE_08
  assign soft_set      = (wr_pend & (wr_addr == REG_SOFTRST) & hwdata[SOFTRST_BIT]) | soft_reset_trap;

  // read mux, reserved and unmapped bits read zero
  always_comb begin
    rd_word = '0;
    case (rd_addr)
      REG_PENDING: rd_word[FLAG_W-1:0] = irq_pending_reg;
      REG_MASK:    rd_word[FLAG_W-1:0] = irq_mask_reg;
      REG_ROUTE:   rd_word[ROUTE_W-1:0] = route;
      REG_VBASE:   rd_word[VEC_W-1:0] = vbase;
      REG_STATUS: begin
        rd_word[STATUS_VALID_BIT]                       = irq_req;
        rd_word[STATUS_RANK_LSB +: RANK_W]              = cur_rank;
        rd_word[STATUS_PRIO_LSB +: PRIO_W]              = irq_priority;
        rd_word[VEC_W-1:0]                              = irq_vector;
      end
      default:     rd_word = '0;
    endcase
  end

  // read data loads during the wait cycle and holds afterwards
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (bus_state == BUS_RDWAIT) begin
      hrdata <= rd_word;
    end
  end

  // software control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_reg <= MASK_RST;
      route        <= ROUTE_RST;
      vbase        <= VBASE_RST;
    end else begin
      if (wr_mask_en) begin
        irq_mask_reg <= hwdata[FLAG_W-1:0] & FLAG_IMPL; // RULE_11
      end
      if (wr_route_en) begin
        route <= hwdata[ROUTE_W-1:0];
      end
      if (wr_vbase_en) begin
        vbase <= hwdata[VEC_W-1:0] & VBASE_KEEP;
      end
    end
  end

  // two-flop sync for pin inputs, third stage only for edge detect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= 2'h0;
      pin_s2 <= 2'h0;
      pin_s3 <= 2'h0;
    end else begin
      pin_s1 <= {nmi_irq, ext_user_irq};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // source levels per flag bit; shared slots take one source at a time
  always_comb begin
    src_lvl             = '0;
    src_lvl[BIT_EXT]    = pin_s2[0];                                       // RULE_02
    src_lvl[BIT_WDOG]   = watchdog_irq;                                    // RULE_02
    src_lvl[BIT_TIMER]  = timer_irq;                                       // RULE_11
    src_lvl[BIT_P0RX]   = port0_rx_irq;                                    // RULE_04
    src_lvl[BIT_P0TX]   = port0_tx_irq;                                    // RULE_05
    src_lvl[BIT_SLOT58] = route[ROUTE_SLOT58] ? dma_ch0_irq : port2_rx_irq; // RULE_06
    src_lvl[BIT_SLOT5C] = route[ROUTE_SLOT5C] ? dma_ch1_irq : port2_tx_irq; // RULE_07
    src_lvl[BIT_SLOT68] = route[ROUTE_SLOT68] ? dma_ch2_irq : port1_rx_irq; // RULE_09
    src_lvl[BIT_SLOT6C] = route[ROUTE_SLOT6C] ? dma_ch3_irq : port1_tx_irq; // RULE_10
    src_lvl[BIT_DMA4]   = dma_ch4_irq;                                     // RULE_03
    src_lvl[BIT_DMA5]   = dma_ch5_irq;                                     // RULE_12
  end

  // rising edges set flags; a route change may look like an edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_prev <= '0;
    end else begin
      src_prev <= src_lvl;
    end
  end

  always_comb begin
    set_vec = (src_lvl & ~src_prev) & FLAG_IMPL;
    set_vec[BIT_HOST] = host_set; // RULE_08
  end

  // clear paths: write one to clear, or core acknowledge
  assign ack_take = irq_ack & irq_req;
  always_comb begin
    ack_clr = '0;
    if (ack_take && (cur_rank >= RANK_W'(RANK_FIRST))) begin
      ack_clr[RANK_BIT[cur_rank]] = 1'b1;
    end
  end
  assign clr_vec = ack_clr | (wr_pending_en ? hwdata[FLAG_W-1:0] : '0);

  // pending flags; a new event beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_pending_reg <= '0;
    end else begin
      irq_pending_reg <= ((irq_pending_reg & ~clr_vec) | set_vec) & FLAG_IMPL; // RULE_11
    end
  end

  // reset trap and nmi flags; hardware reset leaves a reset request up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_flag <= 1'b1;
      nmi_flag   <= 1'b0;
    end else begin
      if (soft_set) begin
        reset_flag <= 1'b1; // RULE_01
      end else if (ack_take && (cur_rank == RANK_W'(RANK_RESET))) begin
        reset_flag <= 1'b0;
      end
      if (pin_s2[1] & ~pin_s3[1]) begin
        nmi_flag <= 1'b1; // RULE_02
      end else if (ack_take && (cur_rank == RANK_W'(RANK_NMI))) begin
        nmi_flag <= 1'b0;
      end
    end
  end

  // requests by rank; nmi ignores the mask, maskable ranks need both bits
  assign req[RANK_RESET] = reset_flag; // RULE_01
  assign req[RANK_NMI]   = nmi_flag;   // RULE_02
  genvar r;
  generate
    for (r = RANK_FIRST; r < NUM_RANK; r++) begin : g_req
      assign req[r] = irq_pending_reg[RANK_BIT[r]] & irq_mask_reg[RANK_BIT[r]]; // RULE_11
    end
  endgenerate

  siv_prio_enc #(
    .N     (NUM_RANK),
    .IDX_W (RANK_W)
  ) u_pick (
    .req   (req),
    .valid (pick_valid),
    .idx   (pick_rank)
  );

  // offered vector; the table only holds 00, 04 and 40 to 74
  // drop request for one cycle after ack so a stale vector is never shown
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_req      <= 1'b0;
      cur_rank     <= '0;
      irq_vector   <= '0;
      irq_priority <= '0;
    end else begin
      irq_req      <= pick_valid & ~ack_take;                   // RULE_13
      cur_rank     <= pick_rank;
      irq_vector   <= {vbase[VEC_W-1:OFF_W], RANK_OFFSET[pick_rank]}; // RULE_03 RULE_13 RULE_14
      irq_priority <= RANK_PRIO[pick_rank];                     // RULE_13
    end
  end
endmodule
`default_nettype wire

// >>> siv_vectoring_asserts.sv
// Purpose: concurrent checks on the core side of the vectoring block
// Assumes: sees top ports only, one clock domain
// Notes:   the stand check skips cycles near bus traffic, since writes move the pick
`timescale 1ns/1ps
`default_nettype none
module siv_vectoring_asserts (
  input wire logic                       hclk,            // bus clock
  input wire logic                       hresetn,         // reset, active low
  input wire logic                       hsel,            // slave select
  input wire logic [1:0]                 htrans,          // transfer type
  input wire logic                       nmi_irq,         // nmi pin
  input wire logic                       soft_reset_trap, // core pulse
  input wire logic                       irq_ack,         // core takes vector
  input wire logic                       irq_req,         // vector offered
  input wire logic [siv_pkg::VEC_W-1:0]  irq_vector,      // base plus offset
  input wire logic [siv_pkg::PRIO_W-1:0] irq_priority     // priority number
);
  import siv_pkg::*;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic bus_now;
  // offset owned by a priority number, 7F where none is
  function automatic logic [6:0] off_of(input logic [4:0] p);
    off_of = 7'h7F;
    for (int r = 0; r < NUM_RANK; r++) begin
      if (RANK_PRIO[r] == p) off_of = RANK_OFFSET[r];
    end
  endfunction
  assign bus_now = hsel && htrans[1];
  property p_reset_first;
    $rose(hresetn) |=> irq_req && irq_priority == 5'h01 && irq_vector == 16'h0000;
  endproperty
  a_reset_first: assert property (p_reset_first) else $error("no reset vector");
  property p_map;
    irq_req |-> irq_vector[6:0] == off_of(irq_priority);
  endproperty
  a_map: assert property (p_map) else $error("offset and priority disagree");
  property p_no_swvec;
    irq_req |-> !(irq_vector[6:0] inside {[7'h08:7'h3C]});
  endproperty
  a_no_swvec: assert property (p_no_swvec) else $error("software vector offered");
  property p_no_rsvd;
    irq_req |-> irq_vector[6:0] < 7'h78;
  endproperty
  a_no_rsvd: assert property (p_no_rsvd) else $error("reserved vector offered");
  property p_ack;
    irq_req && irq_ack |=> !irq_req;
  endproperty
  a_ack: assert property (p_ack) else $error("offer kept after ack");
  property p_nmi;
    $rose(nmi_irq) |-> ##[1:8] (irq_req && irq_priority <= 5'h02);
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not offered");
  property p_soft;
    soft_reset_trap |-> ##[1:4] (irq_req && irq_priority == 5'h01);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset not offered");
  property p_hold;
    irq_req && !irq_ack && !bus_now && !$past(bus_now) && !$past(bus_now, 2) && !$past(bus_now, 3)
      |=> irq_req && irq_priority <= $past(irq_priority);
  endproperty
  a_hold: assert property (p_hold) else $error("offer dropped or lowered");
  c_nmi: cover property (irq_req && irq_priority == 5'h02);
  c_last: cover property (irq_req && irq_priority == 5'h10);
  c_ack: cover property (irq_req && irq_ack);
endmodule
`default_nettype wire

// >>> siv_core_model.sv
// Purpose: core side model that takes every vector offered
// Assumes: ack is a one-cycle pulse while a vector stands
// Notes:   slow mode waits four cycles, so a higher source may overtake
`timescale 1ns/1ps
`default_nettype none
module siv_core_model (
  input  wire logic                       hclk,         // bus clock
  input  wire logic                       hresetn,      // reset, active low
  input  wire logic                       slow,         // late ack
  input  wire logic                       irq_req,      // vector offered
  input  wire logic [siv_pkg::VEC_W-1:0]  irq_vector,   // offered vector
  input  wire logic [siv_pkg::PRIO_W-1:0] irq_priority, // offered priority
  output logic                            irq_ack,      // take pulse
  output logic [7:0]                      n_taken,      // vectors taken
  output logic [siv_pkg::VEC_W-1:0]       taken_vec,    // last taken
  output logic [siv_pkg::PRIO_W-1:0]      taken_prio    // last priority
);
  import siv_pkg::*;
  logic [2:0] wait_cnt;
  // record at the ack edge, where the shown vector is the one taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ack    <= 1'b0;
      wait_cnt   <= 3'h0;
      n_taken    <= 8'h00;
      taken_vec  <= '0;
      taken_prio <= '0;
    end else if (irq_ack) begin
      irq_ack    <= 1'b0;
      wait_cnt   <= 3'h0;
      // an ack that meets no offer is ignored by the block, so it counts nothing here
      if (irq_req) begin
        n_taken    <= n_taken + 8'h01;
        taken_vec  <= irq_vector;
        taken_prio <= irq_priority;
      end
    end else if (irq_req) begin
      if (wait_cnt >= (slow ? 3'h4 : 3'h0)) begin
        irq_ack <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> subsystem_interrupt_vectoring_bench.sv
// Purpose: self-checking bench for the vectoring block
// Assumes: sources pulse one cycle, the core model takes every offer
// Notes:   vector base is random per case, so upper vector bits are exercised
`timescale 1ns/1ps
`default_nettype none
module subsystem_interrupt_vectoring_bench;
  import siv_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [7:0]  haddr = 8'h00;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic [16:0] src = 17'h0;
  logic        hreadyout, hresp, irq_ack, irq_req;
  logic [15:0] irq_vector, taken_vec, base;
  logic [4:0]  irq_priority, taken_prio;
  logic [7:0]  n_taken, n_seen;
  int          n_mismatch = 0, tests_run = 0;
  // per source: offset, flag bit, priority, route, other source of a shared slot
  logic [6:0]  c_off [16] = '{7'h44, 7'h4C, 7'h50, 7'h54, 7'h68, 7'h6C, 7'h58, 7'h5C,
                              7'h58, 7'h5C, 7'h68, 7'h6C, 7'h70, 7'h74, 7'h40, 7'h64};
  int          c_bit [16] = '{1, 3, 4, 5, 10, 11, 6, 7, 6, 7, 10, 11, 12, 13, 0, 9};
  int          c_pr [16]  = '{4, 6, 7, 8, 13, 14, 9, 10, 9, 10, 13, 14, 15, 16, 3, 12};
  int          c_rt [16]  = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 2, 4, 8, 0, 0, 0, 0};
  int          c_alt [16] = '{-1, -1, -1, -1, 10, 11, 8, 9, 6, 7, 4, 5, -1, -1, -1, -1};
  always #5 hclk = ~hclk;
  siv_vectoring DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .nmi_irq(src[15]), .ext_user_irq(src[14]),
    .soft_reset_trap(src[16]), .watchdog_irq(src[0]), .timer_irq(src[1]), .port0_rx_irq(src[2]),
    .port0_tx_irq(src[3]), .port1_rx_irq(src[4]), .port1_tx_irq(src[5]), .port2_rx_irq(src[6]),
    .port2_tx_irq(src[7]), .dma_ch0_irq(src[8]), .dma_ch1_irq(src[9]), .dma_ch2_irq(src[10]),
    .dma_ch3_irq(src[11]), .dma_ch4_irq(src[12]), .dma_ch5_irq(src[13]), .irq_ack, .irq_req,
    .irq_vector, .irq_priority);
  siv_core_model core (.hclk, .hresetn, .slow, .irq_req, .irq_vector, .irq_priority, .irq_ack,
    .n_taken, .taken_vec, .taken_prio);
  // one word transfer; ready is sampled at rising edges, read data at the edge that ends the data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("okay response", {31'h0, hresp}, 32'h0);
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic take(input logic [15:0] v, input logic [4:0] p);
    while (n_taken === n_seen) @(negedge hclk);
    n_seen = n_taken;
    check("vector", {16'h0, taken_vec}, {16'h0, v});
    check("priority", {27'h0, taken_prio}, {27'h0, p});
  endtask
  task automatic pulse(input logic [16:0] m);
    @(posedge hclk);
    src <= m;
    @(posedge hclk);
    src <= 17'h0;
  endtask
  function automatic logic [15:0] vec_of(input logic [15:0] b, input logic [6:0] o);
    return {b[15:7], o};
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // under a thousand cycles expected; a hang is cut off far later
  initial begin
    #300000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    void'($urandom(50833));
    n_seen = 8'h00;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    take(16'h0000, 5'h01);
    bus(1'b0, REG_MASK, 32'h0);
    check("mask reset", rd, 32'h0);
    bus(1'b0, 8'h1C, 32'h0);
    check("unmapped read", rd, 32'h0);
    $display("reset test done");
    // every maskable source alone; mask off first so route changes cannot fire
    for (int i = 0; i < 16; i++) begin
      slow <= i[0];
      base = 16'($urandom()) & VBASE_KEEP;
      bus(1'b1, REG_MASK, 32'h0);
      bus(1'b1, REG_VBASE, {16'h0, base | 16'h007F});
      bus(1'b1, REG_ROUTE, 32'(c_rt[i]));
      bus(1'b0, REG_VBASE, 32'h0);
      check("vector base", rd, {16'h0, base});
      bus(1'b0, REG_ROUTE, 32'h0);
      check("route", rd, 32'(c_rt[i]));
      bus(1'b1, REG_PENDING, 32'h0000FFFF);
      bus(1'b1, REG_MASK, 32'h1 << c_bit[i]);
      if (c_alt[i] >= 0) begin
        pulse(17'h1 << c_alt[i]);
        repeat (8) @(negedge hclk);
        check("unrouted taken", 32'(n_taken), 32'(n_seen));
      end
      if (i == 15) bus(1'b1, REG_HOSTCTL, 32'h1);
      else pulse(17'h1 << i);
      take(vec_of(base, c_off[i]), 5'(c_pr[i]));
      bus(1'b0, REG_PENDING, 32'h0);
      check("flag after take", 32'(rd[c_bit[i]]), 32'h0);
      $display("source case %0d done", i);
    end
    bus(1'b1, REG_MASK, 32'h0);
    pulse(17'h08000);
    take(vec_of(base, 7'h04), 5'h02);
    pulse(17'h10000);
    take(vec_of(base, 7'h00), 5'h01);
    bus(1'b1, REG_SOFTRST, 32'h1);
    take(vec_of(base, 7'h00), 5'h01);
    $display("nmi and soft reset test done");
    // three sources together leave lowest number first
    slow <= 1'b1;
    bus(1'b1, REG_PENDING, 32'h0000FFFF);
    bus(1'b1, REG_MASK, {16'h0, FLAG_IMPL});
    pulse(17'h02006);
    take(vec_of(base, 7'h4C), 5'h06);
    take(vec_of(base, 7'h50), 5'h07);
    take(vec_of(base, 7'h74), 5'h10);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    n_seen = 8'h00;
    hresetn <= 1'b1;
    take(16'h0000, 5'h01);
    $display("priority and second reset test done");
    give_verdict();
  end
endmodule
bind siv_vectoring siv_vectoring_asserts u_asserts (.hclk, .hresetn, .hsel, .htrans, .nmi_irq,
  .soft_reset_trap, .irq_ack, .irq_req, .irq_vector, .irq_priority);
`default_nettype wire
